// ===== hw/cpc_pkg.sv
// shared constants and types for the 8-bit processor core
package cpc_pkg;
   // vectors and fixed address pages
   localparam logic [15:0] VEC_NMI    = 16'hFFFA;
   localparam logic [15:0] VEC_RST    = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ    = 16'hFFFE;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   localparam logic [15:0] PC_STEP    = 16'h0001;
   localparam logic [7:0]  STACK_PAGE = 8'h01;
   localparam logic [7:0]  ZERO_PAGE  = 8'h00;
   localparam logic [7:0]  BYTE_ONE   = 8'h01;
   localparam logic [7:0]  REG_RESET  = 8'h00;
   localparam logic [7:0]  SP_RESET   = 8'hFF;

   // status register layout
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_I = 2;
   localparam int FLG_D = 3;
   localparam int FLG_V = 6;
   localparam int FLG_N = 7;
   localparam logic [7:0] P_RESET = 8'h34;
   localparam logic [7:0] P_FORCE = 8'h20;
   localparam logic [7:0] P_BRK   = 8'h10;

   // cycle step counter values
   localparam logic [2:0] ST_0   = 3'h0;
   localparam logic [2:0] ST_1   = 3'h1;
   localparam logic [2:0] ST_2   = 3'h2;
   localparam logic [2:0] ST_3   = 3'h3;
   localparam logic [2:0] ST_4   = 3'h4;
   localparam logic [2:0] ST_INC = 3'h1;

   // decimal correction
   localparam logic [4:0] BCD_MAX = 5'h09;
   localparam logic [4:0] BCD_ADJ = 5'h06;

   // opcode field patterns
   localparam logic [1:0] G1_CODE  = 2'h1;
   localparam logic [4:0] BR_PAT   = 5'h10;
   localparam logic [4:0] FLAG_PAT = 5'h18;
   localparam logic [2:0] AM_INDX  = 3'h0;
   localparam logic [2:0] AM_ZP    = 3'h1;
   localparam logic [2:0] AM_IMM   = 3'h2;
   localparam logic [2:0] AM_ABS   = 3'h3;
   localparam logic [2:0] AM_INDY  = 3'h4;
   localparam logic [2:0] AM_ZPX   = 3'h5;
   localparam logic [2:0] AM_ABSY  = 3'h6;
   localparam logic [2:0] AM_ABSX  = 3'h7;
   localparam logic [2:0] AAA_STORE = 3'h4;
   localparam logic [1:0] SEL_N    = 2'h0;
   localparam logic [1:0] SEL_V    = 2'h1;
   localparam logic [1:0] SEL_C    = 2'h2;

   // opcodes decoded one by one
   localparam logic [7:0] OP_STP  = 8'hDB;
   localparam logic [7:0] OP_WAI  = 8'hCB;
   localparam logic [7:0] OP_JMP  = 8'h4C;
   localparam logic [7:0] OP_JSR  = 8'h20;
   localparam logic [7:0] OP_RTS  = 8'h60;
   localparam logic [7:0] OP_RTI  = 8'h40;
   localparam logic [7:0] OP_PHA  = 8'h48;
   localparam logic [7:0] OP_PHP  = 8'h08;
   localparam logic [7:0] OP_PLA  = 8'h68;
   localparam logic [7:0] OP_PLP  = 8'h28;
   localparam logic [7:0] OP_LDXI = 8'hA2;
   localparam logic [7:0] OP_LDYI = 8'hA0;
   localparam logic [7:0] OP_INX  = 8'hE8;
   localparam logic [7:0] OP_INY  = 8'hC8;
   localparam logic [7:0] OP_DEX  = 8'hCA;
   localparam logic [7:0] OP_DEY  = 8'h88;
   localparam logic [7:0] OP_TAX  = 8'hAA;
   localparam logic [7:0] OP_TXA  = 8'h8A;
   localparam logic [7:0] OP_TAY  = 8'hA8;
   localparam logic [7:0] OP_TYA  = 8'h98;
   localparam logic [7:0] OP_TSX  = 8'hBA;
   localparam logic [7:0] OP_TXS  = 8'h9A;

   // low eight codes follow the group-one operation field
   typedef enum logic [3:0] {
      ALU_OR   = 4'h0,
      ALU_AND  = 4'h1,
      ALU_EOR  = 4'h2,
      ALU_ADC  = 4'h3,
      ALU_HOLD = 4'h4,
      ALU_PASS = 4'h5,
      ALU_CMP  = 4'h6,
      ALU_SBC  = 4'h7,
      ALU_INC  = 4'h8,
      ALU_DEC  = 4'h9
   } cpc_alu_op_t;

   typedef enum logic [1:0] {
      INT_NONE = 2'h0,
      INT_IRQ  = 2'h1,
      INT_NMI  = 2'h2,
      INT_RST  = 2'h3
   } cpc_int_t;
endpackage

// ===== hw/cpc_alu.sv
// stateless arithmetic and logic unit, binary and decimal
`timescale 1ns/1ps
module cpc_alu
   import cpc_pkg::*;
(
   // operands
   input  wire logic [7:0]  i_a,
   input  wire logic [7:0]  i_b,
   input  wire logic        i_carry,
   input  wire logic        i_dec,
   input  wire cpc_alu_op_t i_op,
   // result and flags
   output logic [7:0]       o_res,
   output logic             o_c,
   output logic             o_v,
   output logic             o_z,
   output logic             o_n
);
   always_comb begin
      logic [7:0] bin;
      logic [8:0] sum;
      logic [4:0] lo;
      logic [4:0] hi;
      logic       cin;
      bin = (i_op == ALU_SBC || i_op == ALU_CMP) ? ~i_b : i_b;
      cin = (i_op == ALU_CMP) ? 1'b1 : i_carry;
      sum = {1'b0, i_a} + {1'b0, bin} + {8'h00, cin};
      lo = 5'h00;
      hi = 5'h00;
      o_c = sum[8];
      o_v = (i_a[7] == bin[7]) && (sum[7] != i_a[7]);
      case (i_op)
         ALU_OR:   o_res = i_a | i_b;
         ALU_AND:  o_res = i_a & i_b;
         ALU_EOR:  o_res = i_a ^ i_b;
         ALU_PASS: o_res = i_b;
         ALU_INC:  o_res = i_a + BYTE_ONE;
         ALU_DEC:  o_res = i_a - BYTE_ONE;
         ALU_CMP:  o_res = sum[7:0];
         ALU_ADC, ALU_SBC: begin
            o_res = sum[7:0];
            if (i_dec && i_op == ALU_ADC) begin
               lo = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
               if (lo > BCD_MAX) lo = lo + BCD_ADJ;
               hi = {1'b0, i_a[7:4]} + {1'b0, i_b[7:4]} + {4'h0, lo[4]};
               if (hi > BCD_MAX) hi = hi + BCD_ADJ;
               o_res = {hi[3:0], lo[3:0]};
               o_c = hi[4];
            end else if (i_dec) begin
               // binary carry already equals the decimal borrow
               lo = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, ~cin};
               hi = {1'b0, i_a[7:4]} - {1'b0, i_b[7:4]} - {4'h0, lo[4]};
               if (lo[4]) lo = lo - BCD_ADJ;
               if (hi[4]) hi = hi - BCD_ADJ;
               o_res = {hi[3:0], lo[3:0]};
            end
         end
         default:  o_res = i_a;
      endcase
      o_z = (o_res == ZERO_PAGE);
      o_n = o_res[7];
   end
endmodule

// ===== hw/cpc_core.sv
// 8-bit processor core: decode, step counter, registers, bus
//
// Functional notes
// - step counter clears on fetch, advances per cycle
// - transfers decoded from opcode plus step count
// - fetched opcode latched, decoded with interrupts
// - stateless ALU does data math; PC, SP and address sums are separate
// - 8-bit accumulator takes most ALU results
// - two index registers added to base address
// - indirect supports pre- and post-indexing
// - 8-bit status, seven flags, branches test N, V, C, Z
// - PC bytes drive low and high address
// - PC increments after every program byte fetch
// - stack pointer moves automatically on stack use
// - binary or decimal arithmetic by decimal flag
// - 64K address space, bidirectional 8-bit data
// - halt-clock opcode stops clocking until reset
// - wait opcode sleeps until interrupt request
// - ready input stalls core cycle by cycle
// - reset runs six cycles, then restart vector
// - maskable interrupt pushes PC, status, sets mask
// - non-maskable edge vectors after current instruction
// - falling set-overflow input sets overflow flag
`timescale 1ns/1ps
module cpc_core
   import cpc_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // control inputs
   input  wire logic        i_reset_in_n,
   input  wire logic        i_irq_n,
   input  wire logic        i_nmi_n,
   input  wire logic        i_so_n,
   // ready pin, two-way
   input  wire logic        i_rdy,
   output logic             o_rdy,
   output logic             o_rdy_oe_n,
   // system bus
   output logic [15:0]      o_addr,
   input  wire logic [7:0]  i_data,
   output logic [7:0]       o_data,
   output logic             o_data_oe_n,
   output logic             o_rw,
   output logic             o_sync,
   // phase clocks
   output logic             o_first_phase_clock,
   output logic             o_second_phase_clock
);
   logic [7:0]  a;
   logic [7:0]  x;
   logic [7:0]  y;
   logic [7:0]  sp;
   logic [7:0]  p;
   logic [7:0]  ir;
   logic [7:0]  ptr;
   logic [15:0] pc;
   logic [15:0] ea;
   logic [2:0]  t;
   logic        ph;
   logic        halted;
   logic        waiting;
   logic        nmi_pend;
   logic        nmi_prev;
   logic        so_prev;
   cpc_int_t    ikind;

   logic [7:0]  next_a;
   logic [7:0]  next_x;
   logic [7:0]  next_y;
   logic [7:0]  next_sp;
   logic [7:0]  next_p;
   logic [7:0]  next_ir;
   logic [7:0]  next_ptr;
   logic [15:0] next_pc;
   logic [15:0] next_ea;
   logic [2:0]  next_t;

   logic [15:0] bus_addr;
   logic [7:0]  bus_wdata;
   logic        bus_wr;
   logic        bus_sync;
   logic        fin;
   logic        do_stp;
   logic        do_wai;
   logic        ld_nz;
   logic        exec_rd;

   logic [7:0]  alu_a;
   logic [7:0]  alu_b;
   logic [7:0]  alu_res;
   logic        alu_c;
   logic        alu_v;
   logic        alu_z;
   logic        alu_n;
   cpc_alu_op_t alu_op;

   // opcode fields and addressing-mode decode
   logic [2:0]  aaa;
   logic [2:0]  bbb;
   logic        g1;
   logic        m_abs_any;
   logic        m_ind_any;
   logic        oper;
   logic        br_taken;
   logic        in_int;
   logic        int_req;
   logic        run;
   logic        cyc_go;
   logic        nmi_fall;
   logic        so_fall;
   logic [15:0] stk;
   logic [15:0] vec;

   assign aaa       = ir[7:5];
   assign bbb       = ir[4:2];
   assign g1        = (ir[1:0] == G1_CODE);
   assign m_abs_any = (bbb == AM_ABS) || (bbb == AM_ABSX) || (bbb == AM_ABSY);
   assign m_ind_any = (bbb == AM_INDX) || (bbb == AM_INDY);
   assign oper = ((t == ST_2) && (bbb == AM_ZP || bbb == AM_ZPX))
              || ((t == ST_3) && m_abs_any)
              || ((t == ST_4) && m_ind_any);
   assign stk       = {STACK_PAGE, sp};
   assign in_int    = (ikind != INT_NONE);
   // interrupts are only looked at on an opcode boundary
   assign int_req   = (ikind == INT_RST) || nmi_pend
                   || (!i_irq_n && !p[FLG_I]);
   assign vec = (ikind == INT_RST) ? VEC_RST :
                (ikind == INT_NMI) ? VEC_NMI : VEC_IRQ;
   assign run      = !halted && !waiting && i_reset_in_n;
   assign cyc_go   = ph && run && i_rdy;
   assign nmi_fall = nmi_prev && !i_nmi_n;
   assign so_fall  = so_prev && !i_so_n;

   always_comb begin
      case (ir[7:6])
         SEL_N:   br_taken = (p[FLG_N] == ir[5]);
         SEL_V:   br_taken = (p[FLG_V] == ir[5]);
         SEL_C:   br_taken = (p[FLG_C] == ir[5]);
         default: br_taken = (p[FLG_Z] == ir[5]);
      endcase
   end

   // operand routing into the arithmetic unit
   always_comb begin
      alu_a  = a;
      alu_b  = i_data;
      alu_op = ALU_PASS;
      case (ir)
         OP_INX, OP_DEX: begin
            alu_a  = x;
            alu_op = (ir == OP_INX) ? ALU_INC : ALU_DEC;
         end
         OP_INY, OP_DEY: begin
            alu_a  = y;
            alu_op = (ir == OP_INY) ? ALU_INC : ALU_DEC;
         end
         OP_TAX, OP_TAY: alu_b = a;
         OP_TXA:         alu_b = x;
         OP_TYA:         alu_b = y;
         OP_TSX:         alu_b = sp;
         default: begin
            if (g1) alu_op = cpc_alu_op_t'({1'b0, aaa});
         end
      endcase
   end

   cpc_alu u_alu (
      .i_a     (alu_a),
      .i_b     (alu_b),
      .i_carry (p[FLG_C]),
      .i_dec   (p[FLG_D]),
      .i_op    (alu_op),
      .o_res   (alu_res),
      .o_c     (alu_c),
      .o_v     (alu_v),
      .o_z     (alu_z),
      .o_n     (alu_n)
   );

   // per-cycle decode of opcode and step count
   always_comb begin
      next_a = a;
      next_x = x;
      next_y = y;
      next_sp = sp;
      next_p = p;
      next_ir = ir;
      next_ptr = ptr;
      next_pc = pc;
      next_ea = ea;
      next_t = t + ST_INC;
      bus_addr = pc;
      bus_wdata = a;
      bus_wr = 1'b0;
      bus_sync = 1'b0;
      fin = 1'b0;
      do_stp = 1'b0;
      do_wai = 1'b0;
      ld_nz = 1'b0;
      exec_rd = 1'b0;
      if (t == ST_0) begin
         if (!int_req) begin
            bus_sync = 1'b1;
            next_ir = i_data;
            next_pc = pc + PC_STEP;
         end
      end else if (in_int) begin
         // reset reads where interrupts write, same six cycles
         bus_addr = stk;
         bus_wr = (ikind != INT_RST);
         case (t)
            ST_1: begin
               bus_wdata = pc[15:8];
               next_sp = sp - BYTE_ONE;
            end
            ST_2: begin
               bus_wdata = pc[7:0];
               next_sp = sp - BYTE_ONE;
            end
            ST_3: begin
               bus_wdata = (p | P_FORCE) & ~P_BRK;
               next_sp = sp - BYTE_ONE;
               next_p[FLG_I] = 1'b1;
               next_p[FLG_D] = 1'b0;
            end
            ST_4: begin
               bus_wr = 1'b0;
               bus_addr = vec;
               next_ptr = i_data;
            end
            default: begin
               bus_wr = 1'b0;
               bus_addr = vec + PC_STEP;
               next_pc = {i_data, ptr};
               fin = 1'b1;
            end
         endcase
      end else begin
         case (ir)
            OP_STP: begin
               do_stp = 1'b1;
               fin = 1'b1;
            end
            OP_WAI: begin
               do_wai = 1'b1;
               fin = 1'b1;
            end
            OP_JMP, OP_JSR: begin
               if (t == ST_1) begin
                  next_ptr = i_data;
                  next_pc = pc + PC_STEP;
               end else if (ir == OP_JSR && t != ST_4) begin
                  bus_addr = stk;
                  bus_wr = 1'b1;
                  bus_wdata = (t == ST_2) ? pc[15:8] : pc[7:0];
                  next_sp = sp - BYTE_ONE;
               end else begin
                  next_pc = {i_data, ptr};
                  fin = 1'b1;
               end
            end
            OP_RTS, OP_RTI: begin
               bus_addr = stk;
               if (ir == OP_RTI && t == ST_2) next_p = i_data | P_FORCE;
               if ((ir == OP_RTS && t == ST_2) || t == ST_3) next_ptr = i_data;
               if ((ir == OP_RTS && t == ST_3) || t == ST_4) begin
                  next_pc = {i_data, ptr};
                  if (ir == OP_RTS) next_pc = {i_data, ptr} + PC_STEP;
                  fin = 1'b1;
               end else begin
                  next_sp = sp + BYTE_ONE;
               end
            end
            OP_PHA, OP_PHP: begin
               bus_addr = stk;
               bus_wr = 1'b1;
               bus_wdata = (ir == OP_PHP) ? (p | P_FORCE | P_BRK) : a;
               next_sp = sp - BYTE_ONE;
               fin = 1'b1;
            end
            OP_PLA, OP_PLP: begin
               bus_addr = stk;
               if (t == ST_1) begin
                  next_sp = sp + BYTE_ONE;
               end else begin
                  if (ir == OP_PLA) next_a = alu_res;
                  if (ir == OP_PLP) next_p = i_data | P_FORCE;
                  ld_nz = (ir == OP_PLA);
                  fin = 1'b1;
               end
            end
            OP_LDXI, OP_LDYI: begin
               next_pc = pc + PC_STEP;
               if (ir == OP_LDXI) next_x = alu_res;
               if (ir == OP_LDYI) next_y = alu_res;
               ld_nz = 1'b1;
               fin = 1'b1;
            end
            OP_INX, OP_DEX, OP_TAX, OP_TSX: begin
               next_x = alu_res;
               ld_nz = 1'b1;
               fin = 1'b1;
            end
            OP_INY, OP_DEY, OP_TAY: begin
               next_y = alu_res;
               ld_nz = 1'b1;
               fin = 1'b1;
            end
            OP_TXA, OP_TYA: begin
               next_a = alu_res;
               ld_nz = 1'b1;
               fin = 1'b1;
            end
            OP_TXS: begin
               next_sp = x;
               fin = 1'b1;
            end
            default: begin
               fin = 1'b1;
               if (ir[4:0] == BR_PAT) begin
                  next_pc = pc + PC_STEP;
                  if (br_taken) begin
                     next_pc = pc + PC_STEP + {{8{i_data[7]}}, i_data};
                  end
               end else if (ir[4:0] == FLAG_PAT) begin
                  case (ir[7:6])
                     SEL_N:   next_p[FLG_C] = ir[5];
                     SEL_V:   next_p[FLG_I] = ir[5];
                     SEL_C:   next_p[FLG_V] = 1'b0;
                     default: next_p[FLG_D] = ir[5];
                  endcase
               end else if (g1 && t == ST_1) begin
                  next_pc = pc + PC_STEP;
                  exec_rd = (bbb == AM_IMM) && (aaa != AAA_STORE);
                  fin = (bbb == AM_IMM);
                  // pre-index for the zero-page pointer
                  next_ptr = i_data + ((bbb == AM_INDX) ? x : ZERO_PAGE);
                  next_ea = {ZERO_PAGE,
                             i_data + ((bbb == AM_ZPX) ? x : ZERO_PAGE)};
               end else if (g1 && oper) begin
                  bus_addr = ea;
                  bus_wr = (aaa == AAA_STORE);
                  exec_rd = (aaa != AAA_STORE);
               end else if (g1 && m_abs_any) begin
                  fin = 1'b0;
                  next_pc = pc + PC_STEP;
                  next_ea = {i_data, ptr}
                          + {ZERO_PAGE, (bbb == AM_ABS) ? ZERO_PAGE :
                                        (bbb == AM_ABSY) ? y : x};
               end else if (g1 && t == ST_2) begin
                  fin = 1'b0;
                  bus_addr = {ZERO_PAGE, ptr};
                  next_ea = {ZERO_PAGE, i_data};
                  next_ptr = ptr + BYTE_ONE;
               end else if (g1) begin
                  fin = 1'b0;
                  bus_addr = {ZERO_PAGE, ptr};
                  // post-index applied to the fetched pointer
                  next_ea = {i_data, ea[7:0]}
                          + {ZERO_PAGE, (bbb == AM_INDY) ? y : ZERO_PAGE};
               end
            end
         endcase
      end
      if (exec_rd) begin
         ld_nz = 1'b1;
         if (alu_op != ALU_CMP) next_a = alu_res;
         if (alu_op == ALU_ADC || alu_op == ALU_SBC) begin
            next_p[FLG_C] = alu_c;
            next_p[FLG_V] = alu_v;
         end
         if (alu_op == ALU_CMP) next_p[FLG_C] = alu_c;
      end
      if (ld_nz) begin
         next_p[FLG_N] = alu_n;
         next_p[FLG_Z] = alu_z;
      end
      if (fin) next_t = ST_0;
   end

   // two phases per bus cycle; frozen by the halt-clock opcode
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ph <= 1'b0;
      end else if (!halted) begin
         ph <= ~ph;
      end
   end

   assign o_second_phase_clock = ph;
   assign o_first_phase_clock  = ~ph;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         a <= REG_RESET;
         x <= REG_RESET;
         y <= REG_RESET;
         sp <= SP_RESET;
         ir <= REG_RESET;
         ptr <= REG_RESET;
         pc <= PC_RESET;
         ea <= PC_RESET;
         t <= ST_0;
      end else if (!i_reset_in_n) begin
         t <= ST_0;
      end else if (cyc_go) begin
         a <= next_a;
         x <= next_x;
         y <= next_y;
         sp <= next_sp;
         ir <= next_ir;
         ptr <= next_ptr;
         pc <= next_pc;
         ea <= next_ea;
         t <= next_t;
      end
   end

   // status register; the pin edge wins over a same-cycle write
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         p <= P_RESET;
         so_prev <= 1'b1;
      end else begin
         so_prev <= i_so_n;
         if (cyc_go) p <= next_p;
         if (so_fall) p[FLG_V] <= 1'b1;
      end
   end

   // interrupt sensing and sequence kind
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ikind <= INT_RST;
         nmi_pend <= 1'b0;
         nmi_prev <= 1'b1;
      end else begin
         nmi_prev <= i_nmi_n;
         if (nmi_fall) begin
            nmi_pend <= 1'b1;
         end else if (cyc_go && t == ST_0 && !in_int && nmi_pend) begin
            nmi_pend <= 1'b0;
         end
         if (!i_reset_in_n) begin
            ikind <= INT_RST;
         end else if (cyc_go && t == ST_0 && !in_int && int_req) begin
            ikind <= nmi_pend ? INT_NMI : INT_IRQ;
         end else if (cyc_go && in_int && fin) begin
            ikind <= INT_NONE;
         end
      end
   end

   // halt and wait states
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !i_reset_in_n) begin
         halted <= 1'b0;
         waiting <= 1'b0;
      end else begin
         if (cyc_go && do_stp) halted <= 1'b1;
         if (waiting && (!i_irq_n || nmi_pend)) begin
            waiting <= 1'b0;
         end else if (cyc_go && do_wai) begin
            waiting <= 1'b1;
         end
      end
   end

   // ready pin is pulled low while waiting for an interrupt
   assign o_rdy      = 1'b0;
   assign o_rdy_oe_n = ~waiting;

   // bus outputs settle at the end of phase one; writes last one phase
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_addr <= PC_RESET;
         o_data <= REG_RESET;
         o_data_oe_n <= 1'b1;
         o_rw <= 1'b1;
         o_sync <= 1'b0;
      end else if (!ph && run) begin
         o_addr <= bus_addr;
         o_data <= bus_wdata;
         o_data_oe_n <= ~bus_wr;
         o_rw <= ~bus_wr;
         o_sync <= bus_sync;
      end else if (ph || !run) begin
         o_data_oe_n <= 1'b1;
         o_rw <= 1'b1;
      end
   end
endmodule

// ===== verif/cpc_core_sva.sv
// port-level assertion checker for the processor core
`timescale 1ns/1ps
module cpc_core_sva
   import cpc_pkg::*;
(
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_reset_in_n,
   input wire logic        i_rdy,
   input wire logic [7:0]  i_data,
   input wire logic [15:0] o_addr,
   input wire logic        o_rw,
   input wire logic        o_data_oe_n,
   input wire logic        o_sync,
   input wire logic        o_first_phase_clock,
   input wire logic        o_second_phase_clock
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire ph2 = o_second_phase_clock;
   // a completed cycle: phase two, not stalled, not held in reset
   wire go = ph2 && i_rdy && i_reset_in_n;
   sequence s_lo; go && o_addr == VEC_RST; endsequence
   sequence s_hi; go && o_addr == 16'hFFFD; endsequence
   sequence s_sta; go && o_sync && i_data == 8'h8D ##2 go ##2 go; endsequence
   a_write_phase: assert property (
      !o_rw |-> ph2 && !o_data_oe_n) else $error("write outside phase two");
   a_fetch_read: assert property (
      o_sync |-> o_rw) else $error("opcode fetch not a read");
   a_phase_inverse: assert property (
      ph2 |=> !ph2 && o_first_phase_clock) else $error("phase clocks overlap");
   a_stall_holds: assert property (
      ph2 && !i_rdy && i_reset_in_n |=> ($stable(o_addr) && $stable(o_sync))[*2])
      else $error("stalled cycle moved");
   a_pc_step: assert property (
      go && o_sync && (i_data == 8'hA9 || i_data == 8'h8D)
      |-> ##2 o_addr == $past(o_addr, 2) + 16'h0001)
      else $error("counter did not step");
   a_vector_next: assert property (
      s_lo |-> ##2 o_addr == 16'hFFFD) else $error("vector high not read");
   a_nmi_vector: assert property (
      go && o_addr == VEC_NMI |-> ##2 o_addr == 16'hFFFB)
      else $error("nmi vector high not read");
   a_restart_load: assert property (
      s_lo ##2 s_hi |-> ##2 o_sync && o_addr == {$past(i_data, 2), $past(i_data, 4)})
      else $error("restart vector not loaded");
   a_store_addr: assert property (
      s_sta |-> ##2 !o_rw && o_addr == {$past(i_data, 2), $past(i_data, 4)})
      else $error("store address wrong");
   a_halt_freeze: assert property (
      go && o_sync && i_data == OP_STP |-> ##6 $stable(ph2) && $stable(o_addr))
      else $error("halt did not freeze");
endmodule
bind cpc_core cpc_core_sva chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_reset_in_n(i_reset_in_n), .i_rdy(i_rdy), .i_data(i_data),
   .o_addr(o_addr), .o_rw(o_rw), .o_data_oe_n(o_data_oe_n), .o_sync(o_sync),
   .o_first_phase_clock(o_first_phase_clock),
   .o_second_phase_clock(o_second_phase_clock));

// ===== verif/cpc_mem.sv
// behavioural memory on the far side of the system bus
`timescale 1ns/1ps
module cpc_mem (
   // bus from the core
   input  wire logic        i_clk,
   input  wire logic [15:0] i_addr,
   input  wire logic        i_rw,
   input  wire logic [7:0]  i_wdata,
   // read data
   output logic [7:0]       o_rdata
);
   logic [7:0] mem [0:65535];
   // full 64K space, read answers within phase two
   assign o_rdata = mem[i_addr];
   // plain process: the bench preloads this array as well
   always @(posedge i_clk) begin
      if (!i_rw) begin
         mem[i_addr] <= i_wdata;
      end
   end
endmodule

// ===== verif/tb_top.sv
// self-checking bench for the processor core
`timescale 1ns/1ps
module tb_top
   import cpc_pkg::*;
;
   logic        i_clk = 1'b0, i_rst_n = 1'b0, rin_n = 1'b0, ext_rdy = 1'b1;
   logic        nmi_n = 1'b1;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, bus;
   logic        rw, oe_n, sync, ph2, rdy_o, rdy_oe_n, rdy_w;
   int          failures = 0, comparisons = 0, nmi_wait = 0;
   // ready wire is pulled up; the core can only pull it low
   assign rdy_w = ext_rdy & (rdy_oe_n | rdy_o);
   assign bus   = oe_n ? rdata : wdata;
   // rows: decimal mode, first operand, second operand, sum
   logic [24:0] rows [4] = '{{1'b0, 8'h12, 8'h34, 8'h46},
      {1'b1, 8'h19, 8'h28, 8'h47}, {1'b0, 8'hFF, 8'h01, 8'h00},
      {1'b1, 8'h99, 8'h01, 8'h00}};
   cpc_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_in_n(rin_n),
      .i_irq_n(1'b1), .i_nmi_n(nmi_n), .i_so_n(1'b1), .i_rdy(rdy_w),
      .o_rdy(rdy_o), .o_rdy_oe_n(rdy_oe_n), .o_addr(addr), .i_data(bus),
      .o_data(wdata), .o_data_oe_n(oe_n), .o_rw(rw), .o_sync(sync),
      .o_first_phase_clock(), .o_second_phase_clock(ph2));
   cpc_mem mem_u (.i_clk(i_clk), .i_addr(addr), .i_rw(rw),
      .i_wdata(wdata), .o_rdata(rdata));
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // program: mode, clear carry, load, add, store to 0300, halt
   task run(input logic [24:0] r, input bit stall);
      logic [7:0]  p [10];
      logic [15:0] held;
      int          n;
      p = '{r[24] ? 8'hF8 : 8'hD8, 8'h18, 8'hA9, r[23:16], 8'h69, r[15:8],
         8'h8D, 8'h00, 8'h03, OP_STP};
      foreach (p[i]) mem_u.mem[16'h0200 + i] = p[i];
      mem_u.mem[VEC_RST] = 8'h00;
      mem_u.mem[16'hFFFD] = 8'h02;
      mem_u.mem[16'h0300] = 8'hEE;
      @(posedge i_clk) rin_n <= 1'b0;
      repeat (3) @(posedge i_clk);
      rin_n <= 1'b1;
      n = 0;
      while (n < 400) begin
         @(posedge i_clk) ext_rdy <= !stall || (n % 3 != 1);
         @(negedge i_clk);
         if (sync && ph2 && addr == 16'h0209) break;
         n++;
      end
      chk({15'h0, n < 400}, 16'h0001);
      chk({8'h0, mem_u.mem[16'h0300]}, {8'h0, r[7:0]});
      @(posedge i_clk) ext_rdy <= 1'b1;
      repeat (10) @(negedge i_clk);
      held = addr;
      repeat (20) @(negedge i_clk);
      chk(addr, held);
   endtask
   initial begin
      repeat (2) @(negedge i_clk);
      chk(addr, 16'h0000);
      chk({11'h0, rw, oe_n, sync, rdy_oe_n, ph2}, 16'h001A);
      @(posedge i_clk) i_rst_n <= 1'b1;
      foreach (rows[i]) run(rows[i], 1'b0);
      run(rows[1], 1'b1);
      // handler is a lone return, so the stored sum must survive it
      mem_u.mem[VEC_NMI] = 8'h00;
      mem_u.mem[16'hFFFB] = 8'h04;
      mem_u.mem[16'h0400] = OP_RTI;
      fork
         run(rows[0], 1'b0);
         begin
            repeat (30) @(posedge i_clk);
            nmi_n <= 1'b0;
            while (nmi_wait < 400 && !(sync && ph2 && addr == 16'h0400)) begin
               @(negedge i_clk);
               nmi_wait++;
            end
            chk({15'h0, nmi_wait < 400}, 16'h0001);
         end
      join
      give_verdict();
   end
   initial begin
      #50000;
      failures++;
      give_verdict();
   end
endmodule
